// *** hdl/ptc_pkg.sv ***
// shared types and constants for the pileup timing and trace capture block
package ptc_pkg;
   // sample timing
   localparam int CLK_PERIOD_NS   = 10;
   localparam int SAMPLE_NS       = 20;
   localparam int CLK_PER_SAMPLE  = SAMPLE_NS / CLK_PERIOD_NS;
   // trace capture
   localparam int TRACE_LEN       = 4096;
   localparam int TRACE_AW        = 12;
   localparam int TRACE_DW        = 16;
   localparam logic [15:0] TRACE_MIDPOINT = 16'h8000;
   localparam int TRACE_IVL_MIN_NS = 20;
   localparam int TRACE_IVL_MAX_NS = 1000000;
   localparam int TRACE_IVL_MIN   = TRACE_IVL_MIN_NS / SAMPLE_NS;
   localparam int TRACE_IVL_MAX   = TRACE_IVL_MAX_NS / SAMPLE_NS;
   // energy filter gap limits in decimated ticks
   localparam logic [6:0] GAP_MIN = 7'h03;
   localparam logic [6:0] GAP_MAX = 7'h40;
   // reset values
   localparam logic [15:0] TIME_RST = 16'h0000;

   typedef enum logic [2:0] {
      PTC_SRC_ADC,
      PTC_SRC_BL_AVG,
      PTC_SRC_FAST,
      PTC_SRC_BL_FILT,
      PTC_SRC_ENERGY,
      PTC_SRC_BL_SAMP,
      PTC_SRC_E_SAMP
   } ptc_src_e;

   // host configuration, all times in adc sample ticks except gap
   typedef struct packed {
      logic        invert;          // invert adc codes
      logic [1:0]  decimation;      // decimated tick = 2**decimation samples
      logic [15:0] trig_threshold;  // fast filter threshold (signed)
      logic [15:0] max_over_threshold_time;
      logic [15:0] peaking_time;
      logic [6:0]  gap_time;        // decimated ticks
      logic [15:0] peak_int_offset;
      logic [15:0] peak_samp_offset;
      ptc_src_e    trace_src;
      logic [15:0] trace_interval;  // samples between stored points
   } ptc_cfg_s;

   // filter waveforms from the upstream pipeline
   typedef struct packed {
      logic [15:0] fast;
      logic [15:0] bl_filt;
      logic [15:0] energy;
      logic [15:0] bl_avg;
      logic [15:0] bl_samp;
   } ptc_filt_s;
endpackage : ptc_pkg

// *** hdl/ptc_top.sv ***
// pileup timing checks, energy sampling, polarity and trace capture
`timescale 1ns/1ps
// What this block and its host do
// (RL1) Over-threshold fast trigger longer than max width is rejected as pileup.
// (RL2) Host sets max width above twice fast peaking plus preamp risetime.
// (RL3) Events closer than the peak interval are slow pileup and excluded.
// (RL4) Peak interval equals peaking plus gap plus interval offset.
// (RL5) Host normally leaves the interval offset at zero.
// (RL6) Host uses 100 ns fast peaking, maybe 60 ns for short energy.
// (RL7) Host keeps fast filter gap at zero.
// (RL8) Energy sampled at peaking plus gap minus sample offset.
// (RL9) A trace stores 4096 samples of a chosen 16-bit waveform.
// (RL10) Signed trace values are shifted so zero reads 32768.
// (RL11) Trace sources: adc, bl average, fast, bl filter, energy, samples.
// (RL12) At decimation 0 the baseline filter source shows the energy filter.
// (RL13) Trace interval spans 0.020 to 1000 microseconds.
// (RL14) Shortest interval is one 20 ns sample, every sample stored.
// (RL15) Polarity setting inverts adc codes; adc trace shows inverted data.
// (RL16) Baseline average is subtracted from the energy filter output.
// (RL17) Gap is whole decimated ticks within 3 to 64.
// (RL18) Only decimation 0 allows gap below 3, down to zero.
// (RL19) Capture starts on request, sets done, buffer holds until next.
module ptc_top (
   input  wire logic                core_clk,
   input  wire logic                rst_n,
   input  wire logic                ce,
   input  wire ptc_pkg::ptc_cfg_s   cfg,
   input  wire logic                adc_valid,
   input  wire logic [15:0]         adc_code,
   input  wire ptc_pkg::ptc_filt_s  filt,
   input  wire logic                trace_start,
   input  wire logic [11:0]         trace_rd_addr,
   output logic [15:0]              adc_to_filter,
   output logic                     adc_to_filter_valid,
   output logic [15:0]              energy_corr,
   output logic                     energy_valid,
   output logic [15:0]              energy_value,
   output logic                     pileup_fast,
   output logic                     pileup_slow,
   output logic                     trace_busy,
   output logic                     trace_done,
   output logic [15:0]              trace_rd_data
);
   import ptc_pkg::*;

   // signed-to-trace offset, unsigned passes through
   // flipping the top bit adds 32768 modulo 2**16
   function automatic logic [15:0] to_trace(input logic [15:0] v, input logic sgn);
      to_trace = sgn ? (v ^ TRACE_MIDPOINT) : v;
   endfunction : to_trace

   // gap in sample ticks after decimation limits
   // limits apply before the shift so a clamped gap still scales with decimation
   function automatic logic [15:0] gap_ticks(input logic [6:0] g, input logic [1:0] d);
      logic [6:0] c;
      c = g;
      if (g > GAP_MAX) c = GAP_MAX;
      if (d != 2'h0 && g < GAP_MIN) c = GAP_MIN;
      gap_ticks = 16'({9'h000, c} << d);
   endfunction : gap_ticks

   logic [15:0] gap_r;
   logic [15:0] samp_pt_r;
   logic [15:0] pk_int_r;
   logic [15:0] evt_cnt_r;
   logic        evt_act_r;
   logic        evt_pile_r;
   logic        evt_fast_r;
   logic        sampled_r;
   logic [15:0] samp_hold_r;
   logic        over_r;
   logic [15:0] over_cnt_r;
   logic [15:0] corr_nxt;
   logic        over_now;
   logic        trig;
   logic        samp_now;
   logic [15:0] samp_sel;

   // (RL17) gap clamp, (RL18) zero gap only at decimation 0
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         gap_r <= TIME_RST;
      end else if (ce) begin
         gap_r <= gap_ticks(cfg.gap_time, cfg.decimation);
      end
   end

   // (RL4) peak interval and (RL8) sampling point
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         pk_int_r  <= TIME_RST;
         samp_pt_r <= TIME_RST;
      end else if (ce) begin
         pk_int_r  <= 16'(cfg.peaking_time + gap_r + cfg.peak_int_offset);
         // an offset past the flattop end clamps to count 0, the first sample after the trigger
         samp_pt_r <= (cfg.peak_samp_offset > 16'(cfg.peaking_time + gap_r)) ? TIME_RST :
                      16'(cfg.peaking_time + gap_r - cfg.peak_samp_offset);
      end
   end

   // (RL15) optional inversion ahead of the filter pipeline
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         adc_to_filter       <= 16'h0000;
         adc_to_filter_valid <= 1'b0;
      end else if (ce) begin
         adc_to_filter_valid <= adc_valid;
         // code held between samples for the trace mux
         if (adc_valid) begin
            adc_to_filter <= cfg.invert ? ~adc_code : adc_code;
         end
      end
   end

   // (RL16) baseline average removed from energy filter
   assign corr_nxt = 16'(filt.energy - filt.bl_avg);
   // sample point and decision may share one sample: the live value is used then
   assign samp_now = evt_cnt_r == samp_pt_r;
   assign samp_sel = samp_now ? corr_nxt : samp_hold_r;
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         energy_corr <= 16'h0000;
      end else if (ce && adc_valid) begin
         energy_corr <= corr_nxt;
      end
   end

   // fast filter above threshold, rising edge is a trigger
   // edge taken sample to sample so idle clocks between samples cannot fake one
   assign over_now = $signed(filt.fast) > $signed(cfg.trig_threshold);
   assign trig     = adc_valid && over_now && !over_r;

   // counter saturates so a stuck trigger cannot wrap back under the limit
   // (RL1) time over threshold
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         over_r     <= 1'b0;
         over_cnt_r <= TIME_RST;
      end else if (ce && adc_valid) begin
         over_r <= over_now;
         if (!over_now) begin
            over_cnt_r <= TIME_RST;
         end else if (over_cnt_r != 16'hffff) begin
            over_cnt_r <= 16'(over_cnt_r + 16'h0001);
         end
      end
   end

   // event timing: sample point, interval end, pileup marks
   // counter reads 0 on the sample after the trigger and steps once per sample
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         evt_act_r   <= 1'b0;
         evt_cnt_r   <= TIME_RST;
         evt_pile_r  <= 1'b0;
         evt_fast_r  <= 1'b0;
         sampled_r   <= 1'b0;
         samp_hold_r <= 16'h0000;
      end else if (ce && adc_valid) begin
         if (trig) begin
            // (RL3) new event inside the interval piles both
            evt_pile_r <= evt_act_r;
            evt_act_r  <= 1'b1;
            evt_cnt_r  <= TIME_RST;
            evt_fast_r <= 1'b0;
            sampled_r  <= 1'b0;
         end else if (evt_act_r) begin
            evt_cnt_r <= 16'(evt_cnt_r + 16'h0001);
            // (RL1) width exceeded marks the event
            if (over_now && over_cnt_r >= cfg.max_over_threshold_time) begin
               evt_fast_r <= 1'b1;
            end
            // (RL8) energy sample taken
            if (evt_cnt_r == samp_pt_r) begin
               samp_hold_r <= corr_nxt;
               sampled_r   <= 1'b1;
            end
            if (evt_cnt_r >= pk_int_r && evt_cnt_r >= samp_pt_r) begin
               evt_act_r <= 1'b0;
            end
         end
      end
   end

   // accept or reject decision at the end of the peak interval
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         energy_valid <= 1'b0;
         energy_value <= 16'h0000;
         pileup_fast  <= 1'b0;
         pileup_slow  <= 1'b0;
      end else if (ce) begin
         energy_valid <= 1'b0;
         pileup_fast  <= 1'b0;
         pileup_slow  <= 1'b0;
         if (adc_valid && evt_act_r) begin
            if (trig) begin
               // (RL3) earlier event cut short by a new trigger
               pileup_slow <= 1'b1;
            end else if (evt_cnt_r >= pk_int_r && evt_cnt_r >= samp_pt_r) begin
               if (evt_pile_r) begin
                  pileup_slow <= 1'b1;
               end else if (evt_fast_r) begin
                  // (RL1) rejected as fast pileup
                  pileup_fast <= 1'b1;
               end else if (sampled_r || samp_now) begin
                  // (RL8) negative energies clip to zero
                  energy_valid <= 1'b1;
                  energy_value <= samp_sel[15] ? 16'h0000 : samp_sel;
               end
            end
         end
      end
   end

   // trace capture state
   // done holds until the next start so the host may read at leisure
   typedef enum logic [1:0] {TR_IDLE, TR_RUN, TR_DONE} ptc_tr_e;
   ptc_tr_e       tr_st_r;
   logic [15:0]   tr_mem [TRACE_LEN];
   logic [11:0]   tr_wa_r;
   logic [15:0]   tr_ivl_r;
   logic [15:0]   tr_div_r;
   logic [15:0]   tr_src_v;
   logic [15:0]   tr_ivl_nxt;
   logic          tr_take;

   // (RL11) source mux with (RL10) midpoint offset
   always_comb begin
      tr_src_v = 16'h0000;
      unique case (cfg.trace_src)
         // (RL15) adc trace after inversion
         PTC_SRC_ADC:     tr_src_v = adc_to_filter;
         PTC_SRC_BL_AVG:  tr_src_v = to_trace(filt.bl_avg, 1'b1);
         PTC_SRC_FAST:    tr_src_v = to_trace(filt.fast, 1'b1);
         // (RL12) decimation 0 shows the energy filter
         PTC_SRC_BL_FILT: tr_src_v = to_trace(cfg.decimation == 2'h0 ?
                                     filt.energy : filt.bl_filt, 1'b1);
         PTC_SRC_ENERGY:  tr_src_v = to_trace(filt.energy, 1'b1);
         PTC_SRC_BL_SAMP: tr_src_v = to_trace(filt.bl_samp, 1'b1);
         PTC_SRC_E_SAMP:  tr_src_v = energy_value;
         // code 7 is unused and reads zero
         default:         tr_src_v = 16'h0000;
      endcase
   end

   // (RL13) interval clamped to 1..50000 samples, (RL14) 1 stores each
   always_comb begin
      tr_ivl_nxt = cfg.trace_interval;
      if (cfg.trace_interval < 16'(TRACE_IVL_MIN)) tr_ivl_nxt = 16'(TRACE_IVL_MIN);
      if (cfg.trace_interval > 16'(TRACE_IVL_MAX)) tr_ivl_nxt = 16'(TRACE_IVL_MAX);
   end

   assign tr_take = (tr_st_r == TR_RUN) && adc_to_filter_valid && tr_div_r == 16'h0000;

   // (RL19) start on request, done after the last sample
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         tr_st_r    <= TR_IDLE;
         tr_wa_r    <= 12'h000;
         tr_ivl_r   <= 16'h0001;
         tr_div_r   <= 16'h0000;
         trace_busy <= 1'b0;
         trace_done <= 1'b0;
      end else if (ce) begin
         if (trace_start && tr_st_r != TR_RUN) begin
            tr_st_r    <= TR_RUN;
            tr_wa_r    <= 12'h000;
            tr_ivl_r   <= tr_ivl_nxt;
            tr_div_r   <= 16'h0000;
            trace_busy <= 1'b1;
            trace_done <= 1'b0;
         end else if (tr_st_r == TR_RUN && adc_to_filter_valid) begin
            tr_div_r <= (tr_div_r == 16'(tr_ivl_r - 16'h0001)) ? 16'h0000 :
                        16'(tr_div_r + 16'h0001);
            if (tr_take) begin
               tr_wa_r <= 12'(tr_wa_r + 12'h001);
               // (RL9) 4096 points fill the buffer
               if (tr_wa_r == 12'(TRACE_LEN - 1)) begin
                  tr_st_r    <= TR_DONE;
                  trace_busy <= 1'b0;
                  trace_done <= 1'b1;
               end
            end
         end
      end
   end

   // no reset on the buffer so it can map onto block memory
   // (RL9) buffer write; held stable outside a capture
   always_ff @(posedge core_clk) begin
      if (ce && tr_take) begin
         tr_mem[tr_wa_r] <= tr_src_v;
      end
   end

   // registered readout
   // reading mid-capture returns a mix of old and new points
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         trace_rd_data <= 16'h0000;
      end else if (ce) begin
         trace_rd_data <= tr_mem[trace_rd_addr];
      end
   end
endmodule : ptc_top

// *** verif/ptc_adc_model.sv ***
// adc partner model: one ramping code per 20 ns sample
`timescale 1ns/1ps
module ptc_adc_model (
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   output logic             adc_valid,
   output logic [15:0]      adc_code
);
   logic [15:0] cnt_r;
   // sample pulse every second clock; line toggles between samples
   initial begin
      adc_valid = 1'b0;
      adc_code  = 16'h0000;
      cnt_r     = 16'h0100;
      forever begin
         @(posedge core_clk);
         #1;
         adc_valid = rst_n && !adc_valid;
         if (adc_valid) cnt_r = cnt_r + 16'h0001;
         adc_code = adc_valid ? cnt_r : ~cnt_r;
      end
   end
endmodule : ptc_adc_model

// *** verif/ptc_top_props.sv ***
// concurrent port checks for the pileup timing and trace capture block
`timescale 1ns/1ps
module ptc_top_props (
   input wire logic                core_clk,
   input wire logic                rst_n,
   input wire logic                ce,
   input wire ptc_pkg::ptc_cfg_s   cfg,
   input wire logic                adc_valid,
   input wire logic [15:0]         adc_code,
   input wire ptc_pkg::ptc_filt_s  filt,
   input wire logic                trace_start,
   input wire logic [11:0]         trace_rd_addr,
   input wire logic [15:0]         adc_to_filter,
   input wire logic                adc_to_filter_valid,
   input wire logic [15:0]         energy_corr,
   input wire logic                energy_valid,
   input wire logic [15:0]         energy_value,
   input wire logic                pileup_fast,
   input wire logic                pileup_slow,
   input wire logic                trace_busy,
   input wire logic                trace_done,
   input wire logic [15:0]         trace_rd_data
);
   import ptc_pkg::*;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   a_adc_invert: assert property (ce && adc_valid |=>
      adc_to_filter == ($past(cfg.invert) ? ~$past(adc_code) : $past(adc_code)))
      else $error("adc code path wrong");
   a_adc_valid: assert property (ce && adc_valid |=> adc_to_filter_valid)
      else $error("adc valid not forwarded");
   a_energy_sub: assert property (ce && adc_valid |=>
      energy_corr == $past(filt.energy) - $past(filt.bl_avg)) else $error("baseline not removed");
   a_ce_freeze: assert property (!ce |=> $stable(adc_to_filter) && $stable(energy_value)
      && $stable(trace_busy)) else $error("state moved with ce low");
   a_start_busy: assert property (ce && trace_start && !trace_busy |=> trace_busy)
      else $error("capture did not start");
   a_busy_done: assert property (!(trace_busy && trace_done))
      else $error("busy and done together");
   a_done_hold: assert property (trace_done && !(ce && trace_start) |=> trace_done)
      else $error("done dropped without request");
   a_done_cause: assert property ($rose(trace_done) |-> $past(trace_busy) && !trace_busy)
      else $error("done without capture");
   a_buf_stable: assert property (trace_done && $past(trace_done) && $stable(trace_rd_addr)
      |=> $stable(trace_rd_data)) else $error("buffer changed after done");
   a_slow_excl: assert property (pileup_slow |-> !energy_valid && !pileup_fast)
      else $error("slow pileup event accepted");
   a_fast_excl: assert property (pileup_fast |-> !energy_valid)
      else $error("fast pileup event accepted");
endmodule : ptc_top_props
bind ptc_top ptc_top_props u_props (
   .core_clk(core_clk), .rst_n(rst_n), .ce(ce), .cfg(cfg), .adc_valid(adc_valid),
   .adc_code(adc_code), .filt(filt), .trace_start(trace_start), .trace_rd_addr(trace_rd_addr),
   .adc_to_filter(adc_to_filter), .adc_to_filter_valid(adc_to_filter_valid),
   .energy_corr(energy_corr), .energy_valid(energy_valid), .energy_value(energy_value),
   .pileup_fast(pileup_fast), .pileup_slow(pileup_slow), .trace_busy(trace_busy),
   .trace_done(trace_done), .trace_rd_data(trace_rd_data));

// *** verif/ptc_top_tb.sv ***
// self-checking bench for the pileup timing and trace capture block
`timescale 1ns/1ps
module ptc_top_tb;
   import ptc_pkg::*;
   logic            core_clk, rst_n, ce, trace_start, adc_valid, adc_to_filter_valid, last_inv;
   logic            energy_valid, pileup_fast, pileup_slow, trace_busy, trace_done;
   logic [15:0]     adc_code, adc_to_filter, energy_corr, energy_value, trace_rd_data, v;
   logic [15:0]     base, e_v, a_v, f_v, last_code, last_e;
   logic [11:0]     trace_rd_addr, a;
   ptc_cfg_s        cfg;
   ptc_filt_s       filt;
   int              num_errors, compares, cycles, n_ev, n_ps, n_pf, n;
   int              ev [5][6] = '{'{3, 0, 1, 0, 0, 0}, '{20, 0, 0, 0, 1, 0},
                                  '{3, 4, 0, 2, 0, 0}, '{3, 30, 2, 0, 0, 0},
                                  '{3, 30, 0, 2, 0, 20}};
   int              tr [6][3] = '{'{0, 1, 0}, '{0, 3, 1}, '{2, 1, 0}, '{3, 1, 0},
                                  '{6, 1, 0}, '{3, 1, 1}};

   ptc_adc_model u_adc (.core_clk(core_clk), .rst_n(rst_n), .adc_valid(adc_valid),
                        .adc_code(adc_code));
   ptc_top dut (.core_clk(core_clk), .rst_n(rst_n), .ce(ce), .cfg(cfg), .adc_valid(adc_valid),
      .adc_code(adc_code), .filt(filt), .trace_start(trace_start),
      .trace_rd_addr(trace_rd_addr), .adc_to_filter(adc_to_filter),
      .adc_to_filter_valid(adc_to_filter_valid), .energy_corr(energy_corr),
      .energy_valid(energy_valid), .energy_value(energy_value), .pileup_fast(pileup_fast),
      .pileup_slow(pileup_slow), .trace_busy(trace_busy), .trace_done(trace_done),
      .trace_rd_data(trace_rd_data));

   // free running 100 MHz clock
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // pulse counters, accepted sample record and hang guard
   always @(posedge core_clk) begin
      cycles++;
      n_ev += energy_valid;
      n_ps += pileup_slow;
      n_pf += pileup_fast;
      if (ce && adc_valid) begin
         last_code <= adc_code;
         last_inv  <= cfg.invert;
         last_e    <= filt.energy - filt.bl_avg;
      end
      if (cycles == 80000) begin
         num_errors++;
         complete_run();
      end
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic tick(input int k);
      repeat (k) @(posedge core_clk);
      #1;
   endtask : tick

   task automatic pulse(input int w);
      filt.fast = 16'h0200;
      tick(2 * w);
      filt.fast = 16'h0000;
   endtask : pulse

   task automatic read_word(input logic [11:0] ad, output logic [15:0] d);
      trace_rd_addr = ad;
      tick(2);
      d = trace_rd_data;
   endtask : read_word

   function automatic logic [15:0] trace_exp(input int src, input int ivl, input int inv);
      case (src)
         0: return inv ? base - 16'(a * ivl) : base + 16'(a * ivl);
         2: return f_v ^ TRACE_MIDPOINT;
         3: return (inv ? ~e_v : e_v) ^ TRACE_MIDPOINT;
         6: return 16'(e_v - a_v);
         default: return e_v ^ TRACE_MIDPOINT;
      endcase
   endfunction : trace_exp

   task automatic complete_run;
      $display("num_errors=%0d compares=%0d", num_errors, compares);
      if (num_errors == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : complete_run

   // main sequence
   initial begin
      void'($urandom(87197));
      {rst_n, trace_start, trace_rd_addr, filt} = '0;
      ce = 1'b1;
      cfg = '0;
      // width above twice fast peaking, offsets zero
      cfg.trig_threshold = 16'h0100;
      cfg.max_over_threshold_time = 16'h000c;
      cfg.peaking_time = 16'h0010;
      cfg.gap_time = 7'h03;
      cfg.trace_interval = 16'h0001;
      e_v = 16'h1000 + 16'($urandom % 16'h2000);
      a_v = 16'($urandom % 16'h0800);
      f_v = 16'($urandom);
      tick(2);
      rst_n = 1'b1;
      check(energy_value, 16'h0000);
      for (int i = 0; i < 300; i++) begin
         ce = ($urandom % 8) != 0;
         cfg.invert = 1'($urandom);
         filt.energy = 16'($urandom);
         filt.bl_avg = 16'($urandom);
         tick(1);
         if (adc_to_filter_valid === 1'b1) begin
            check(adc_to_filter, last_inv ? ~last_code : last_code);
            check(energy_corr, last_e);
         end
      end
      {ce, cfg.invert, filt} = {1'b1, 1'b0, 16'h0000, ~e_v, e_v, a_v, 16'h0000};
      tick(8);
      for (int k = 0; k < 5; k++) begin
         {n_ev, n_ps, n_pf} = '0;
         // last row widens the peak interval by an offset
         cfg.peak_int_offset = 16'(ev[k][5]);
         pulse(ev[k][0]);
         if (ev[k][1] > 0) begin
            tick(2 * ev[k][1]);
            pulse(3);
         end
         tick(120);
         check(16'(n_ev), 16'(ev[k][2]));
         check(16'(n_ps), 16'(ev[k][3]));
         check(16'(n_pf), 16'(ev[k][4]));
         if (ev[k][2] > 0) check(energy_value, e_v - a_v);
      end
      filt.fast = f_v;
      for (int k = 0; k < 6; k++) begin
         cfg.trace_src = ptc_src_e'(tr[k][0]);
         cfg.trace_interval = 16'(tr[k][1]);
         cfg.invert = tr[k][2][0];
         // third column on the baseline filter source selects decimation 1
         cfg.decimation = 2'(tr[k][0] == 3 ? tr[k][2] : 0);
         tick(4);
         trace_start = 1'b1;
         tick(1);
         trace_start = 1'b0;
         check({15'h0000, trace_busy}, 16'h0001);
         n = 0;
         while (trace_done !== 1'b1 && n < 30000) begin
            tick(1);
            n++;
         end
         check({15'h0000, trace_done}, 16'h0001);
         read_word(12'h000, base);
         for (int j = 0; j < 6; j++) begin
            a = (j == 5) ? 12'hfff : 12'($urandom);
            read_word(a, v);
            check(v, trace_exp(tr[k][0], tr[k][1], tr[k][2]));
         end
      end
      complete_run();
   end
endmodule : ptc_top_tb
